/* File: logic/dcsc_ramp.v */
// Purpose: frequency ramp generator stepping 0.1 Hz at a time toward a target
// Assumes: step periods are given in clock cycles by the parent
// Notes:   below the floor the fast period applies so the floor is reached in one second
module dcsc_ramp #(
	parameter W = 16
) (
	// clock and reset
	input  wire         pclk,
	input  wire         presetn,
	// settings
	input  wire [W-1:0] target,
	input  wire [W-1:0] floor_frequency,
	input  wire [31:0]  up_period,
	input  wire [31:0]  down_period,
	input  wire [31:0]  floor_period,
	// result
	output reg  [W-1:0] freq_reg
);
	reg  [31:0] tick_reg;
	wire        below = (freq_reg < floor_frequency);
	wire        up    = (freq_reg < target);
	wire [31:0] per   = below ? floor_period : (up ? up_period : down_period);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			freq_reg <= {W{1'b0}};
			tick_reg <= 32'h0;
		end
		else if (freq_reg == target)
			tick_reg <= 32'h0;
		else if (tick_reg + 32'h1 >= per)
		begin
			tick_reg <= 32'h0;
			if (up)
				freq_reg <= freq_reg + {{(W-1){1'b0}}, 1'b1};
			else
				freq_reg <= freq_reg - {{(W-1){1'b0}}, 1'b1};
		end
		else
			tick_reg <= tick_reg + 32'h1;
	end
endmodule

/* File: logic/dcsc_regs.vh */
// Purpose: register map, field positions, reset values and timing for the drive config/speed block
// Assumes: apb with 32-bit data, byte addresses, one register per aligned word
// Notes:   frequencies are in units of 0.1 Hz
`ifndef DCSC_REGS_VH
`define DCSC_REGS_VH

`define DCSC_OFF_CTRL       12'h000
`define DCSC_OFF_FREQ       12'h004
`define DCSC_OFF_RAMP       12'h008
`define DCSC_OFF_OVL        12'h00c
`define DCSC_OFF_STATUS     12'h010
`define DCSC_OFF_CMD        12'h014
`define DCSC_OFF_ANALOG     12'h018

// control register fields
`define DCSC_CTRL_CFG_LSB   0
`define DCSC_CTRL_CFG_MSB   3
`define DCSC_CTRL_RESTART   4
`define DCSC_CTRL_VECTOR    5
`define DCSC_CTRL_CURRENT   6
`define DCSC_CTRL_RESET     32'h0000_0000

// command register pulse bits
`define DCSC_CMD_AUTO       0
`define DCSC_CMD_OFF        1
`define DCSC_CMD_LOCAL      2
`define DCSC_CMD_RUN        3
`define DCSC_CMD_STOP       4
`define DCSC_CMD_ARROWS     5

// frequency register: floor in [15:0], ceiling in [31:16]
`define DCSC_FLOOR_RESET    16'h012c
`define DCSC_CEIL_RESET     16'h0258
// ramp register: start-up seconds [15:0], shut-down seconds [31:16]
`define DCSC_RAMP_RESET     32'h0008_0008
// overload threshold in 0.1 A
`define DCSC_OVL_RESET      16'h0064
`define DCSC_ANALOG_FULL    12'hfff

// modes
`define DCSC_MODE_OFF       2'h0
`define DCSC_MODE_AUTO      2'h1
`define DCSC_MODE_LOCAL     2'h2

// timing
`define DCSC_CLK_HZ         20000000
`define DCSC_FLOOR_RAMP_S   1
`define DCSC_OVL_CLASS_S    10
`define DCSC_OVL_LIMIT      32'd200000000

`endif

/* File: logic/dcsc_top.v */
// Purpose: system configuration decode, run gating and frequency command for a motor drive
// Assumes: contacts are closed-high dry contact levels from pins; analog input is a 12-bit sample
// Notes:   frequency units are 0.1 Hz; constant-pressure loops live outside, fed by cp outputs
//
// Our own choices: the APB register port and the register offsets.
`include "dcsc_regs.vh"

module dcsc_top #(
	parameter CLK_HZ      = `DCSC_CLK_HZ,
	parameter FLOOR_CYC   = `DCSC_CLK_HZ * `DCSC_FLOOR_RAMP_S,
	parameter OVL_LIMIT   = `DCSC_OVL_LIMIT
) (
	// apb
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// contacts, analog source and motor current
	input  wire        run_permit_contact_a,
	input  wire        run_permit_contact_b,
	input  wire        direction_select_contact,
	input  wire        drive_off_contact,
	input  wire [11:0] analog_level,
	input  wire [15:0] motor_current,
	// power stage
	output reg         run_reg,
	output reg         reverse_reg,
	output reg         line_module_off_reg,
	output reg         load_module_off_reg,
	output reg         vector_mode_reg,
	output reg         cp_analog_reg,
	output reg         cp_digital_reg,
	output reg         overpressure_en_reg,
	output reg         overload_trip_reg,
	output wire [15:0] freq_command
);
	// synchronisers for pins
	reg  [3:0]  cont_s1_reg;
	reg  [3:0]  cont_reg;
	reg  [11:0] ana_s1_reg;
	reg  [11:0] ana_reg;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cont_s1_reg <= 4'h0;
			cont_reg    <= 4'h0;
			ana_s1_reg  <= 12'h000;
			ana_reg     <= 12'h000;
		end
		else
		begin
			cont_s1_reg <= {drive_off_contact, direction_select_contact,
				run_permit_contact_b, run_permit_contact_a};
			cont_reg    <= cont_s1_reg;
			ana_s1_reg  <= analog_level;
			ana_reg     <= ana_s1_reg;
		end
	end
	wire c_a   = cont_reg[0];
	wire c_b   = cont_reg[1];
	wire c_dir = cont_reg[2];
	wire c_off = cont_reg[3];

	// registers
	reg  [31:0] ctrl_reg;
	reg  [15:0] floor_frequency_reg;
	reg  [15:0] ceil_reg;
	reg  [31:0] ramp_reg;
	reg  [15:0] overload_threshold_reg;
	reg  [1:0]  mode_reg;
	reg         local_run_reg;
	reg         dir_latch_reg;
	reg         init_reg;

	wire        wr     = psel & penable & pwrite;
	wire        hit    = (paddr == `DCSC_OFF_CTRL) | (paddr == `DCSC_OFF_FREQ) | (paddr == `DCSC_OFF_RAMP) |
		(paddr == `DCSC_OFF_OVL) | (paddr == `DCSC_OFF_STATUS) | (paddr == `DCSC_OFF_CMD) |
		(paddr == `DCSC_OFF_ANALOG);
	wire        cmd_wr = wr & (paddr == `DCSC_OFF_CMD);
	wire [3:0]  cfg    = ctrl_reg[`DCSC_CTRL_CFG_MSB:`DCSC_CTRL_CFG_LSB];

	// zero-wait slave; unmapped addresses answer with an error
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg               <= `DCSC_CTRL_RESET;
			floor_frequency_reg    <= `DCSC_FLOOR_RESET;
			ceil_reg               <= `DCSC_CEIL_RESET;
			ramp_reg               <= `DCSC_RAMP_RESET;
			overload_threshold_reg <= `DCSC_OVL_RESET;
		end
		else if (wr)
		begin
			case (paddr)
			`DCSC_OFF_CTRL:
				ctrl_reg <= {26'h0, pwdata[5:0]};
			`DCSC_OFF_FREQ:
			begin
				floor_frequency_reg <= pwdata[15:0];
				ceil_reg            <= pwdata[31:16];
			end
			`DCSC_OFF_RAMP:
				ramp_reg <= pwdata;
			`DCSC_OFF_OVL:
				overload_threshold_reg <= pwdata[15:0];
			default:
				ctrl_reg <= ctrl_reg;
			endcase
		end
	end

	// operating mode; restart option sampled one cycle after reset release
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_reg      <= `DCSC_MODE_OFF;
			init_reg      <= 1'b1;
			local_run_reg <= 1'b0;
		end
		else
		begin
			init_reg <= 1'b0;
			if (init_reg)
				mode_reg <= ctrl_reg[`DCSC_CTRL_RESTART] ? `DCSC_MODE_AUTO : `DCSC_MODE_OFF;
			else if (cmd_wr & pwdata[`DCSC_CMD_OFF])
				mode_reg <= `DCSC_MODE_OFF;
			else if (cmd_wr & pwdata[`DCSC_CMD_AUTO])
				mode_reg <= `DCSC_MODE_AUTO;
			else if (cmd_wr & pwdata[`DCSC_CMD_LOCAL])
				mode_reg <= `DCSC_MODE_LOCAL;
			if (mode_reg != `DCSC_MODE_LOCAL || (cmd_wr & pwdata[`DCSC_CMD_STOP]))
				local_run_reg <= 1'b0;
			else if (cmd_wr & pwdata[`DCSC_CMD_RUN])
				local_run_reg <= 1'b1;
		end
	end

	// config 10 direction contact latch; open state held until both arrows pressed
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dir_latch_reg <= 1'b0;
		else if (cmd_wr & pwdata[`DCSC_CMD_ARROWS])
			dir_latch_reg <= 1'b0;
		else if (cfg == 4'd10 && run_reg && !c_dir)
			dir_latch_reg <= 1'b1;
	end

	// configuration decode
	reg        permit;
	reg        analog_speed;
	reg        rev;
	reg        cp_a;
	reg        cp_d;
	reg        op_en;
	reg        line_off;
	reg        load_off;
	reg        forced_off;
	wire       two = c_a & c_b;
	always @*
	begin
		permit       = two;
		analog_speed = 1'b0;
		rev          = 1'b0;
		cp_a         = 1'b0;
		cp_d         = 1'b0;
		op_en        = 1'b0;
		line_off     = 1'b0;
		load_off     = 1'b0;
		forced_off   = 1'b0;
		case (cfg)
		4'd0: permit = two;
		4'd1: analog_speed = 1'b1;
		4'd2: cp_a = 1'b1;
		4'd3: cp_d = 1'b1;
		4'd4: rev = c_dir;
		4'd5:
		begin
			analog_speed = 1'b1;
			rev          = c_dir;
		end
		4'd6: load_off = 1'b1;
		4'd7: line_off = 1'b1;
		4'd8, 4'd9:
		begin
			forced_off   = ~c_off;
			permit       = c_off;
			analog_speed = c_dir;
			// while the drive-off contact is open overpressure and both pressure modes stay off and auto running is forced off
			op_en        = c_off & c_dir;
			cp_a         = c_off & ~c_dir & (cfg == 4'd8);
			cp_d         = c_off & ~c_dir & (cfg == 4'd9);
		end
		4'd10:
		begin
			analog_speed = 1'b1;
			permit       = two & ~dir_latch_reg;
		end
		default: permit = 1'b0;
		endcase
	end

	// analog scaling: ceiling * level / full scale, clamped to the floor
	wire [27:0] prod   = ceil_reg * ana_reg;
	wire [27:0] quot   = prod / {16'h0, `DCSC_ANALOG_FULL};
	wire [15:0] scaled = quot[15:0];
	wire [15:0] ana_cmd = (scaled < floor_frequency_reg) ? floor_frequency_reg : scaled;
	wire        auto_run = (mode_reg == `DCSC_MODE_AUTO) & permit & ~forced_off & ~overload_trip_reg;
	wire        run_now  = (local_run_reg & ~overload_trip_reg) | auto_run;
	wire [15:0] target   = !run_now ? 16'h0000 : ((analog_speed && mode_reg == `DCSC_MODE_AUTO) ? ana_cmd : ceil_reg);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run_reg             <= 1'b0;
			reverse_reg         <= 1'b0;
			line_module_off_reg <= 1'b0;
			load_module_off_reg <= 1'b0;
			vector_mode_reg     <= 1'b0;
			cp_analog_reg       <= 1'b0;
			cp_digital_reg      <= 1'b0;
			overpressure_en_reg <= 1'b0;
		end
		else
		begin
			run_reg             <= run_now;
			reverse_reg         <= rev;
			line_module_off_reg <= line_off;
			load_module_off_reg <= load_off;
			vector_mode_reg     <= ctrl_reg[`DCSC_CTRL_VECTOR];
			cp_analog_reg       <= cp_a;
			cp_digital_reg      <= cp_d;
			overpressure_en_reg <= op_en;
		end
	end

	// ramp periods: span (ceil - floor) 0.1 Hz steps in ramp seconds
	wire [15:0] span   = (ceil_reg > floor_frequency_reg) ? ceil_reg - floor_frequency_reg : 16'h0001;
	wire [15:0] fl_div = (floor_frequency_reg == 16'h0) ? 16'h0001 : floor_frequency_reg;
	wire [47:0] up_num = ramp_reg[15:0] * CLK_HZ;
	wire [47:0] dn_num = ramp_reg[31:16] * CLK_HZ;
	wire [47:0] up_q   = up_num / {32'h0, span};
	wire [47:0] dn_q   = dn_num / {32'h0, span};
	wire [31:0] up_per = up_q[31:0];
	wire [31:0] dn_per = dn_q[31:0];
	// rounding down keeps the floor inside one second
	wire [31:0] fl_raw = FLOOR_CYC / {16'h0, fl_div};
	// below the floor take the steeper slope, so a low floor keeps the start-up ramp straight
	wire [31:0] fl_per = (fl_raw > up_per) ? up_per : fl_raw;

	dcsc_ramp #(
		.W (16)
	) u_ramp (
		.pclk            (pclk),
		.presetn         (presetn),
		.target          (target),
		.floor_frequency (floor_frequency_reg),
		.up_period       (up_per),
		.down_period     (dn_per),
		.floor_period    (fl_per),
		.freq_reg        (freq_command)
	);

	// overload: accumulate excess current; trip held until an off command once the sum is below the limit
	reg  [31:0] ovl_acc_reg;
	wire [15:0] excess = motor_current - overload_threshold_reg;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ovl_acc_reg       <= 32'h0;
			overload_trip_reg <= 1'b0;
		end
		else
		begin
			if (motor_current > overload_threshold_reg)
				ovl_acc_reg <= ovl_acc_reg + {16'h0, excess};
			else if (ovl_acc_reg != 32'h0)
				ovl_acc_reg <= ovl_acc_reg - 32'h1;
			if (ovl_acc_reg >= OVL_LIMIT)
				overload_trip_reg <= 1'b1;
			else if (cmd_wr & pwdata[`DCSC_CMD_OFF])
				overload_trip_reg <= 1'b0;
		end
	end

	// read mux
	reg  [31:0] rd_mux;
	always @*
	begin
		case (paddr)
		`DCSC_OFF_CTRL:   rd_mux = ctrl_reg;
		`DCSC_OFF_FREQ:   rd_mux = {ceil_reg, floor_frequency_reg};
		`DCSC_OFF_RAMP:   rd_mux = ramp_reg;
		`DCSC_OFF_OVL:    rd_mux = {16'h0, overload_threshold_reg};
		`DCSC_OFF_STATUS: rd_mux = {freq_command, 3'h0, dir_latch_reg, cont_reg, overload_trip_reg,
			run_reg, mode_reg, reverse_reg, overpressure_en_reg, cp_digital_reg, cp_analog_reg};
		`DCSC_OFF_ANALOG: rd_mux = {20'h0, ana_reg};
		default:          rd_mux = 32'h0;
		endcase
	end

	// read data is taken in the setup cycle and stands from a flip-flop through the access phase;
	// status therefore shows the state one cycle before the access edge
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		else if (psel & ~penable & ~pwrite)
			prdata <= rd_mux;
	end
endmodule

/* File: tb/dcsc_far.sv */
// Purpose: far side: dry contacts, analog source and motor load
// Assumes: the bench picks contact states, level and load
// Notes:   current flows only while the stage runs, as a motor would
module dcsc_far (
	// from bench, and run_reg from the block
	input  logic        pclk,
	input  logic [3:0]  want,
	input  logic [11:0] level,
	input  logic [15:0] load,
	input  logic        run_reg,
	// to block
	output logic        run_permit_contact_a,
	output logic        run_permit_contact_b,
	output logic        direction_select_contact,
	output logic        drive_off_contact,
	output logic [11:0] analog_level,
	output logic [15:0] motor_current
);
	initial
	begin
		{drive_off_contact, direction_select_contact, run_permit_contact_b, run_permit_contact_a} = 4'h0;
		analog_level = 12'h000;
		motor_current = 16'h0000;
	end
	always @(posedge pclk)
	begin
		{drive_off_contact, direction_select_contact, run_permit_contact_b, run_permit_contact_a} <= want;
		analog_level <= level;
		motor_current <= run_reg ? load : 16'h0000;
	end
endmodule

/* File: tb/dcsc_props.sv */
// Purpose: port-level checks for the drive config/speed block
// Assumes: software writes one command bit at a time
// Notes:   config, mode and floor are shadowed from apb writes
module dcsc_props (
	// apb
	input logic        pclk,
	input logic        presetn,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	// contacts
	input logic        run_permit_contact_a,
	input logic        run_permit_contact_b,
	input logic        drive_off_contact,
	// power stage
	input logic        run_reg,
	input logic        reverse_reg,
	input logic        line_module_off_reg,
	input logic        load_module_off_reg,
	input logic        cp_analog_reg,
	input logic        cp_digital_reg,
	input logic        overpressure_en_reg,
	input logic [15:0] freq_command
);
	logic [3:0]  cfg_q;
	logic [1:0]  mode_q;
	logic [1:0]  age_q;
	logic [15:0] floor_q;
	wire         wr = psel && penable && pwrite;
	// decode outputs lag a config write, so only judge them once it has settled
	wire         held = age_q == 2'h3;
	wire         gated = cfg_q inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'ha};
	wire         nogo = mode_q == 2'h0 || mode_q == 2'h1 &&
		(gated && !(run_permit_contact_a && run_permit_contact_b) || cfg_q[3:1] == 3'h4 && !drive_off_contact);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_q   <= 4'h0;
			mode_q  <= 2'h0;
			age_q   <= 2'h3;
			floor_q <= 16'h012c;
		end
		else
		begin
			age_q <= (wr && paddr == 12'h000) ? 2'h0 : age_q + {1'b0, age_q != 2'h3};
			if (wr && paddr == 12'h000)
				cfg_q <= pwdata[3:0];
			if (wr && paddr == 12'h004)
				floor_q <= pwdata[15:0];
			if (wr && paddr == 12'h014 && pwdata[2:0] != 3'h0)
				mode_q <= pwdata[2] ? 2'h2 : {1'b0, pwdata[0]};
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_nogo;
		nogo [*5];
	endsequence
	sequence s_idle;
		!run_reg [*3];
	endsequence
	sequence s_running;
		run_reg [*2];
	endsequence
	property p_gate; s_nogo |-> !run_reg; endproperty
	property p_rev; held && reverse_reg |-> cfg_q inside {4'h4, 4'h5}; endproperty
	property p_load; held |-> load_module_off_reg == (cfg_q == 4'h6); endproperty
	property p_line; held |-> line_module_off_reg == (cfg_q == 4'h7); endproperty
	property p_cpa; held && cp_analog_reg |-> cfg_q == 4'h2 || cfg_q == 4'h8; endproperty
	property p_cpd; held && cp_digital_reg |-> cfg_q == 4'h3 || cfg_q == 4'h9; endproperty
	property p_ovp; overpressure_en_reg |-> !cp_analog_reg && !cp_digital_reg && (!held || cfg_q[3:1] == 3'h4);
	endproperty
	property p_step; freq_command == $past(freq_command) || freq_command == $past(freq_command) + 16'h1 ||
		freq_command + 16'h1 == $past(freq_command); endproperty
	property p_down; s_idle |-> freq_command <= $past(freq_command); endproperty
	property p_floor; s_running ##0 $past(freq_command) >= floor_q |-> freq_command >= floor_q; endproperty
	a_gate: assert property (p_gate) else $error("run not permitted");
	a_rev: assert property (p_rev) else $error("reverse in wrong config");
	a_load: assert property (p_load) else $error("load module state");
	a_line: assert property (p_line) else $error("line module state");
	a_cpa: assert property (p_cpa) else $error("analog pressure config");
	a_cpd: assert property (p_cpd) else $error("digital pressure config");
	a_ovp: assert property (p_ovp) else $error("overpressure enable");
	a_step: assert property (p_step) else $error("frequency jump");
	a_down: assert property (p_down) else $error("rises while stopped");
	a_floor: assert property (p_floor) else $error("below floor");
endmodule
bind dcsc_top dcsc_props u_dcsc_props (
	.pclk (pclk), .presetn (presetn), .psel (psel), .penable (penable), .pwrite (pwrite), .paddr (paddr),
	.pwdata (pwdata), .run_permit_contact_a (run_permit_contact_a), .run_permit_contact_b (run_permit_contact_b),
	.drive_off_contact (drive_off_contact), .run_reg (run_reg), .reverse_reg (reverse_reg),
	.line_module_off_reg (line_module_off_reg), .load_module_off_reg (load_module_off_reg),
	.cp_analog_reg (cp_analog_reg), .cp_digital_reg (cp_digital_reg),
	.overpressure_en_reg (overpressure_en_reg), .freq_command (freq_command)
);

/* File: tb/dcsc_top_bench.sv */
// Purpose: self-checking bench for the drive config/speed block
// Assumes: short clock rate parameters so ramps last a few thousand cycles
// Notes:   ramp timing is checked with a tenth of slack for step rounding
`define CK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; $display("BAD %0t got %h", $time, a); end end
module dcsc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HZ = 1500;
	localparam int FLC = 600;
	localparam logic [11:0] RA [5] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h01c};
	localparam logic [31:0] RV [5] = '{32'h0, 32'h0258012c, 32'h00080008, 32'h00000064, 32'h0};
	localparam logic [11:0] LV [4] = '{12'hfff, 12'haaa, 12'h555, 12'h555};
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000, level = 12'h000, analog_level;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [15:0] load = 16'h0, motor_current, freq_command, ex;
	logic [3:0]  want = 4'h0;
	logic [7:0]  e;
	logic [5:0]  g;
	logic        pready, pslverr, slv, run_reg, reverse_reg, line_module_off_reg, load_module_off_reg;
	logic        vector_mode_reg, cp_analog_reg, cp_digital_reg, overpressure_en_reg, overload_trip_reg;
	logic        run_permit_contact_a, run_permit_contact_b, direction_select_contact, drive_off_contact;
	int          mismatches = 0, num_checks = 0, t;

	always #25 pclk = ~pclk;
	dcsc_top #(.CLK_HZ(HZ), .FLOOR_CYC(FLC), .OVL_LIMIT(1000)) u_dcsc_top (.*);
	dcsc_far u_dcsc_far (.*);

	task automatic ap(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdat = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cmd(input int b);
		ap(1'b1, 12'h014, 32'h1 << b);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic till(input logic [15:0] f, input int lim);
		t = 0;
		while (freq_command !== f && t < lim)
		begin
			@(posedge pclk);
			t++;
		end
	endtask
	// result bits: check run, run, overpressure, cp digital, cp analog, load off, line off, reverse
	function automatic logic [7:0] dec(input logic [3:0] c, input logic [3:0] k);
		logic pm;
		pm = c == 4'h8 || c == 4'h9;
		dec = {c != 4'h2 && c != 4'h3 && c != 4'ha && (!pm || k[2]), pm ? k[3] : k[0] && k[1], pm && k[3] && k[2],
			c == 4'h3 || c == 4'h9 && k[3] && !k[2], c == 4'h2 || c == 4'h8 && k[3] && !k[2],
			c == 4'h6, c == 4'h7, (c == 4'h4 || c == 4'h5) && k[2]};
	endfunction
	function automatic logic [15:0] an(input int lv, input int fl);
		an = 16'((600 * lv / 4095 < fl) ? fl : 600 * lv / 4095);
	endfunction
	task automatic conclude;
		if (mismatches == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		wt(80000);
		mismatches++;
		conclude();
	end
	initial
	begin
		void'($urandom(9));
		wt(16);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			ap(1'b0, RA[i], 32'h0);
			`CK(rdat, RV[i])
			`CK(slv, i == 4)
		end
		ap(1'b0, 12'h010, 32'h0);
		`CK(rdat[6:4], 3'h0)
		`CK(vector_mode_reg, 1'b0)
		ap(1'b1, 12'h000, 32'h20);
		wt(4);
		`CK(vector_mode_reg, 1'b1)
		cmd(0);
		for (int c = 0; c < 11; c++)
			repeat (3)
			begin
				want <= 4'($urandom);
				ap(1'b1, 12'h000, 32'(c));
				wt(8);
				e = dec(4'(c), want);
				g = {overpressure_en_reg, cp_digital_reg, cp_analog_reg,
					load_module_off_reg, line_module_off_reg, reverse_reg};
				`CK(g, e[5:0])
				if (e[7])
					`CK(run_reg, e[6])
			end
		want <= 4'hf;
		wt(8);
		cmd(5);
		ap(1'b0, 12'h010, 32'h0);
		`CK(rdat[12], 1'b0)
		want <= 4'hb;
		wt(8);
		want <= 4'hf;
		wt(8);
		ap(1'b0, 12'h010, 32'h0);
		`CK(rdat[12], 1'b1)
		cmd(5);
		ap(1'b0, 12'h010, 32'h0);
		`CK(rdat[12], 1'b0)
		ap(1'b1, 12'h000, 32'h0);
		want <= 4'h0;
		ap(1'b1, 12'h008, 32'h00010001);
		till(16'h0, 3 * HZ);
		cmd(2);
		cmd(3);
		till(16'd300, 2 * FLC);
		`CK(t <= HZ, 1'b1)
		`CK(run_reg, 1'b1)
		till(16'd600, 3 * HZ);
		`CK(t > HZ * 9 / 10 && t < HZ * 11 / 10, 1'b1)
		cmd(4);
		wt(5);
		`CK(run_reg, 1'b0)
		till(16'h0, 3 * HZ);
		`CK(freq_command, 16'h0)
		ap(1'b1, 12'h000, 32'h1);
		want <= 4'h3;
		cmd(0);
		for (int i = 0; i < 4; i++)
		begin
			if (i == 3)
				ap(1'b1, 12'h004, 32'h02580032);
			level <= LV[i];
			ex = an(LV[i], i == 3 ? 50 : 300);
			till(ex, 4 * HZ);
			wt(20);
			`CK(freq_command, ex)
		end
		cmd(2);
		cmd(3);
		load <= 16'h0032;
		wt(3000);
		`CK(overload_trip_reg, 1'b0)
		load <= 16'h0190;
		t = 0;
		while (overload_trip_reg !== 1'b1 && t < 20000)
		begin
			@(posedge pclk);
			t++;
		end
		`CK(overload_trip_reg, 1'b1)
		wt(5);
		`CK(run_reg, 1'b0)
		// the integrator must bleed below the limit first, or the held trip wins over the clear
		load <= 16'h0000;
		wt(2500);
		cmd(1);
		wt(3);
		`CK(overload_trip_reg, 1'b0)
		conclude();
	end
endmodule
